// >>> pwr_ctrl_regs.sv
// power control registers on apb with booster clock generation
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`include "pwr_ctrl_consts.svh"

module pwr_ctrl_regs (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [`PADDR_W-1:0] paddr,
    input  wire logic [31:0]        pwdata,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic               fast_internal_oscillator,
    input  wire logic               low_speed_oscillator,
    output logic                    booster_clk,
    output pwr_ctrl_pkg::reg_ctrl_t reg_ctrl
);

    // -------------------------------------------------------------------
    // address decode
    // -------------------------------------------------------------------
    logic hit_bclk;
    logic hit_lcd;
    logic hit_core;
    logic hit_any;
    logic setup;
    logic commit;

    assign hit_bclk = (paddr == `ADDR_BOOSTER_CLK);
    assign hit_lcd  = (paddr == `ADDR_LCD_REG);
    assign hit_core = (paddr == `ADDR_CORE_REG);
    assign hit_any  = hit_bclk | hit_lcd | hit_core;
    assign setup    = psel & ~penable;

    // -------------------------------------------------------------------
    // register state
    // -------------------------------------------------------------------
    pwr_ctrl_pkg::bclk_ctrl_t bclk_q;
    pwr_ctrl_pkg::bclk_ctrl_t bclk_d;
    pwr_ctrl_pkg::reg_ctrl_t  regc_q;
    pwr_ctrl_pkg::reg_ctrl_t  regc_d;
    logic                     pready_q;
    logic                     pready_d;
    logic                     pslverr_q;
    logic                     pslverr_d;
    logic [31:0]              prdata_q;
    logic [31:0]              prdata_d;

    assign commit = psel & penable & pready_q;

    // -------------------------------------------------------------------
    // read image of each register
    // -------------------------------------------------------------------
    logic [7:0] img_bclk;
    logic [7:0] img_lcd;
    logic [7:0] img_core;

    always_comb begin
        // reserved bits read as zero
        img_bclk = 8'h00;
        img_bclk[`BCLK_DIV_MSB:`BCLK_DIV_LSB] =
            bclk_q.booster_divider_select;
        img_bclk[`BCLK_SRC_MSB:`BCLK_SRC_LSB] =
            bclk_q.booster_source_select;
        img_bclk[`BCLK_GATE_BIT] = bclk_q.booster_clock_gate;
        img_lcd = 8'h00;
        img_lcd[`LCD_CORE_REGULATOR_HEAVY_LOAD_PROTECT_BIT] = regc_q.lcd_regulator_heavy_load_protect;
        img_lcd[`LCD_REF_BIT]  = regc_q.reference_level_select;
        img_core = 8'h00;
        img_core[`CORE_CORE_REGULATOR_HEAVY_LOAD_PROTECT_BIT] =
            regc_q.core_regulator_heavy_load_protect;
    end

    // -------------------------------------------------------------------
    // apb slave: no wait states, answer in the first access cycle
    // -------------------------------------------------------------------
    always_comb begin
        bclk_d    = bclk_q;
        regc_d    = regc_q;
        pready_d  = setup;
        pslverr_d = setup & ~hit_any;
        prdata_d  = 32'h0000_0000;
        if (setup && !pwrite) begin
            if (hit_bclk) begin
                prdata_d = {24'h00_0000, img_bclk};
            end else if (hit_lcd) begin
                prdata_d = {24'h00_0000, img_lcd};
            end else if (hit_core) begin
                prdata_d = {24'h00_0000, img_core};
            end
        end
        // only defined bits are stored; reserved bits are dropped
        if (commit && pwrite) begin
            if (hit_bclk) begin
                bclk_d.booster_divider_select =
                    pwdata[`BCLK_DIV_MSB:`BCLK_DIV_LSB];
                bclk_d.booster_source_select = pwr_ctrl_pkg::src_sel_t'(
                    pwdata[`BCLK_SRC_MSB:`BCLK_SRC_LSB]);
                bclk_d.booster_clock_gate = pwdata[`BCLK_GATE_BIT];
            end
            if (hit_lcd) begin
                regc_d.lcd_regulator_heavy_load_protect =
                    pwdata[`LCD_CORE_REGULATOR_HEAVY_LOAD_PROTECT_BIT];
                regc_d.reference_level_select = pwdata[`LCD_REF_BIT];
            end
            if (hit_core) begin
                regc_d.core_regulator_heavy_load_protect =
                    pwdata[`CORE_CORE_REGULATOR_HEAVY_LOAD_PROTECT_BIT];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bclk_q.booster_divider_select     <= `BCLK_DIV_RST;
            bclk_q.booster_source_select      <= pwr_ctrl_pkg::SRC_FAST;
            bclk_q.booster_clock_gate         <= `BCLK_GATE_RST;
            regc_q.lcd_regulator_heavy_load_protect  <= `LCD_CORE_REGULATOR_HEAVY_LOAD_PROTECT_RST;
            regc_q.reference_level_select            <= `LCD_REF_RST;
            regc_q.core_regulator_heavy_load_protect <= `CORE_CORE_REGULATOR_HEAVY_LOAD_PROTECT_RST;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            bclk_q    <= bclk_d;
            regc_q    <= regc_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q  <= prdata_d;
        end
    end

    assign pready   = pready_q;
    assign pslverr  = pslverr_q;
    assign prdata   = prdata_q;
    assign reg_ctrl = regc_q;

    // -------------------------------------------------------------------
    // booster clock divider
    // -------------------------------------------------------------------
    logic                  div_tick;
    logic                  div_cfg_ok;
    logic [`DIV_CNT_W-1:0] div_cnt;

    booster_clk_div booster_clk_div_i (
        .pclk                     (pclk),
        .presetn                  (presetn),
        .fast_internal_oscillator (fast_internal_oscillator),
        .low_speed_oscillator     (low_speed_oscillator),
        .cfg                      (bclk_q),
        .booster_clk              (booster_clk),
        .tick                     (div_tick),
        .cfg_ok                   (div_cfg_ok),
        .cnt                      (div_cnt)
    );

    // -------------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic [3:0] exp_fast_bit;
    logic [3:0] exp_slow_bit;
    assign exp_fast_bit = `DIV_FAST_BASE +
                          {1'b0, bclk_q.booster_divider_select};
    assign exp_slow_bit = `DIV_SLOW_BASE +
                          {1'b0, bclk_q.booster_divider_select};

    property p_field_write(logic hit, logic fld, logic src_bit);
        (commit && pwrite && hit) |=> (fld == $past(src_bit));
    endproperty

    a_fast_ratio_bit: assert property (
        (bclk_q.booster_clock_gate &&
         bclk_q.booster_source_select == pwr_ctrl_pkg::SRC_FAST &&
         bclk_q.booster_divider_select <= `DIV_FAST_MAX && $stable(bclk_q))
        |=> (booster_clk == $past(div_cnt[exp_fast_bit])))
        else $error("fast source divider bit mismatch");

    a_fast_rsv_quiet: assert property (
        (bclk_q.booster_source_select == pwr_ctrl_pkg::SRC_FAST &&
         bclk_q.booster_divider_select == 3'h7) [*2] |-> !booster_clk)
        else $error("booster clock active on reserved fast ratio");

    a_slow_ratio_bit: assert property (
        (bclk_q.booster_clock_gate &&
         bclk_q.booster_source_select == pwr_ctrl_pkg::SRC_SLOW &&
         bclk_q.booster_divider_select <= `DIV_SLOW_MAX && $stable(bclk_q))
        |=> (booster_clk == $past(div_cnt[exp_slow_bit])))
        else $error("slow source divider bit mismatch");

    a_slow_rsv_quiet: assert property (
        (bclk_q.booster_source_select == pwr_ctrl_pkg::SRC_SLOW &&
         bclk_q.booster_divider_select > `DIV_SLOW_MAX) |=> !booster_clk)
        else $error("booster clock active on reserved slow ratio");

    a_div_field_rw: assert property (
        (commit && pwrite && hit_bclk) |=>
        (bclk_q.booster_divider_select ==
         $past(pwdata[`BCLK_DIV_MSB:`BCLK_DIV_LSB])))
        else $error("divider select not stored");

    a_bclk_readback: assert property (
        (setup && !pwrite && hit_bclk && !(commit && pwrite)) |=>
        (prdata == {24'h00_0000, 1'b0, bclk_q.booster_divider_select,
                    bclk_q.booster_source_select, 1'b0,
                    bclk_q.booster_clock_gate}) && pready && !pslverr)
        else $error("booster clock register read back wrong");

    a_src_rsv_quiet: assert property (
        bclk_q.booster_source_select[1] |=> !booster_clk)
        else $error("booster clock active on reserved source");

    a_gate_off_quiet: assert property (
        !bclk_q.booster_clock_gate |=> !booster_clk)
        else $error("booster clock runs while gate is cleared");

    a_lcd_core_regulator_heavy_load_protect_wr: assert property (
        p_field_write(hit_lcd, regc_q.lcd_regulator_heavy_load_protect,
                      pwdata[`LCD_CORE_REGULATOR_HEAVY_LOAD_PROTECT_BIT]))
        else $error("lcd heavy load protect not stored");

    a_ref_level_wr: assert property (
        p_field_write(hit_lcd, reg_ctrl.reference_level_select,
                      pwdata[`LCD_REF_BIT]))
        else $error("reference level select not stored");

    a_core_core_regulator_heavy_load_protect_wr: assert property (
        p_field_write(hit_core, reg_ctrl.core_regulator_heavy_load_protect,
                      pwdata[`CORE_CORE_REGULATOR_HEAVY_LOAD_PROTECT_BIT]))
        else $error("core heavy load protect not stored");

    a_clk_follows_tick: assert property (
        ($changed(booster_clk) && $stable(bclk_q) &&
         ($past(bclk_q) == $past(bclk_q, 2)))
        |-> $past(div_tick, 2))
        else $error("booster clock moved without a source edge");

    a_unmapped_err: assert property (
        (setup && !hit_any) |=> (pslverr && pready && prdata == 32'h0))
        else $error("unmapped access not answered with error");

    a_pready_pulse: assert property (
        pready |=> !pready)
        else $error("pready held for more than one cycle");

    a_mapped_no_err: assert property (
        (setup && hit_any) |=> (pready && !pslverr))
        else $error("mapped access answered with error");

    a_unmapped_no_write: assert property (
        (commit && pwrite && !hit_any) |=>
        ($stable(bclk_q) && $stable(regc_q)))
        else $error("unmapped write changed a register");

    a_src_field_rw: assert property (
        (commit && pwrite && hit_bclk) |=>
        (bclk_q.booster_source_select ==
         $past(pwdata[`BCLK_SRC_MSB:`BCLK_SRC_LSB])))
        else $error("source select not stored");

    a_gate_field_rw: assert property (
        p_field_write(hit_bclk, bclk_q.booster_clock_gate,
                      pwdata[`BCLK_GATE_BIT]))
        else $error("booster clock gate not stored");

    a_lcd_readback: assert property (
        (setup && !pwrite && hit_lcd) |=>
        (prdata == {24'h00_0000, 3'b000,
                    regc_q.lcd_regulator_heavy_load_protect, 3'b000,
                    regc_q.reference_level_select}))
        else $error("lcd regulator register read back wrong");

    a_core_readback: assert property (
        (setup && !pwrite && hit_core) |=>
        (prdata == {24'h00_0000, 2'b00,
                    regc_q.core_regulator_heavy_load_protect, 5'b00000}))
        else $error("core regulator register read back wrong");

    c_fast_run: cover property (
        bclk_q.booster_clock_gate &&
        bclk_q.booster_source_select == pwr_ctrl_pkg::SRC_FAST &&
        $rose(booster_clk));

    c_slow_run: cover property (
        bclk_q.booster_clock_gate &&
        bclk_q.booster_source_select == pwr_ctrl_pkg::SRC_SLOW &&
        $rose(booster_clk));

    c_lcd_write: cover property (commit && pwrite && hit_lcd);

    c_unmapped: cover property (commit && pslverr);

    c_reserved_code: cover property (
        bclk_q.booster_clock_gate &&
        bclk_q.booster_divider_select == 3'h7);

endmodule : pwr_ctrl_regs

// >>> pwr_ctrl_consts.svh
// register offsets, field positions, reset values and divider constants
`ifndef PWR_CTRL_CONSTS_SVH
`define PWR_CTRL_CONSTS_SVH

// -----------------------------------------------------------------------
// register indices and byte addresses (byte address = 4 * index)
// -----------------------------------------------------------------------
`define PADDR_W          20
`define IDX_BOOSTER_CLK  16'h5071
`define IDX_LCD_REG      16'h50a3
`define IDX_CORE_REG     16'h5120
`define ADDR_BOOSTER_CLK 20'h141c4
`define ADDR_LCD_REG     20'h1428c
`define ADDR_CORE_REG    20'h14480

// -----------------------------------------------------------------------
// field positions
// -----------------------------------------------------------------------
`define BCLK_DIV_MSB     6
`define BCLK_DIV_LSB     4
`define BCLK_SRC_MSB     3
`define BCLK_SRC_LSB     2
`define BCLK_GATE_BIT    0
`define LCD_CORE_REGULATOR_HEAVY_LOAD_PROTECT_BIT     4
`define LCD_REF_BIT      0
`define CORE_CORE_REGULATOR_HEAVY_LOAD_PROTECT_BIT    5

// -----------------------------------------------------------------------
// reset values
// -----------------------------------------------------------------------
`define BCLK_DIV_RST     3'h0
`define BCLK_SRC_RST     2'h0
`define BCLK_GATE_RST    1'b0
`define LCD_CORE_REGULATOR_HEAVY_LOAD_PROTECT_RST     1'b0
`define LCD_REF_RST      1'b0
`define CORE_CORE_REGULATOR_HEAVY_LOAD_PROTECT_RST    1'b0

// -----------------------------------------------------------------------
// divider: output bit = base + code; fast /64 is bit 5, slow /8 is bit 2
// -----------------------------------------------------------------------
`define DIV_CNT_W        12
`define DIV_FAST_BASE    4'h5
`define DIV_SLOW_BASE    4'h2
`define DIV_FAST_MAX     3'h6
`define DIV_SLOW_MAX     3'h3

`endif

// >>> pwr_ctrl_pkg.sv
// types shared by the power control register block
package pwr_ctrl_pkg;

    // -------------------------------------------------------------------
    // booster clock source codes
    // -------------------------------------------------------------------
    typedef enum logic [1:0] {
        SRC_FAST  = 2'b00,
        SRC_SLOW  = 2'b01,
        SRC_RSV_2 = 2'b10,
        SRC_RSV_3 = 2'b11
    } src_sel_t;

    // -------------------------------------------------------------------
    // booster clock control settings
    // -------------------------------------------------------------------
    typedef struct packed {
        logic [2:0] booster_divider_select;
        src_sel_t   booster_source_select;
        logic       booster_clock_gate;
    } bclk_ctrl_t;

    // -------------------------------------------------------------------
    // regulator controls
    // -------------------------------------------------------------------
    typedef struct packed {
        logic lcd_regulator_heavy_load_protect;
        logic reference_level_select;
        logic core_regulator_heavy_load_protect;
    } reg_ctrl_t;

endpackage : pwr_ctrl_pkg

// >>> booster_clk_div.sv
// free-running booster clock divider with source and ratio select
`timescale 1ns/1ps
`include "pwr_ctrl_consts.svh"

module booster_clk_div (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    fast_internal_oscillator,
    input  wire logic                    low_speed_oscillator,
    input  wire pwr_ctrl_pkg::bclk_ctrl_t cfg,
    output logic                         booster_clk,
    output logic                         tick,
    output logic                         cfg_ok,
    output logic [`DIV_CNT_W-1:0]        cnt
);

    // -------------------------------------------------------------------
    // source edge detect and counter
    // -------------------------------------------------------------------
    logic                  fast_q;
    logic                  slow_q;
    logic [`DIV_CNT_W-1:0] cnt_q;
    logic [`DIV_CNT_W-1:0] cnt_d;
    logic                  clk_q;
    logic                  clk_d;
    logic [3:0]            bit_sel;

    always_comb begin
        cfg_ok  = 1'b0;
        bit_sel = `DIV_FAST_BASE;
        tick    = 1'b0;
        case (cfg.booster_source_select)
            pwr_ctrl_pkg::SRC_FAST: begin
                tick    = fast_internal_oscillator & ~fast_q;
                cfg_ok  = (cfg.booster_divider_select <= `DIV_FAST_MAX);
                bit_sel = `DIV_FAST_BASE + {1'b0, cfg.booster_divider_select};
            end
            pwr_ctrl_pkg::SRC_SLOW: begin
                tick    = low_speed_oscillator & ~slow_q;
                cfg_ok  = (cfg.booster_divider_select <= `DIV_SLOW_MAX);
                bit_sel = `DIV_SLOW_BASE + {1'b0, cfg.booster_divider_select};
            end
            default: begin
                cfg_ok = 1'b0;
            end
        endcase
        cnt_d = cnt_q + {{(`DIV_CNT_W-1){1'b0}}, tick};
        // reserved codes keep the output low
        clk_d = cfg.booster_clock_gate & cfg_ok & cnt_q[bit_sel];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fast_q <= 1'b0;
            slow_q <= 1'b0;
            cnt_q  <= '0;
            clk_q  <= 1'b0;
        end else begin
            fast_q <= fast_internal_oscillator;
            slow_q <= low_speed_oscillator;
            cnt_q  <= cnt_d;
            clk_q  <= clk_d;
        end
    end

    assign booster_clk = clk_q;
    assign cnt         = cnt_q;

endmodule : booster_clk_div

// >>> placeholder_none.sv
// intentionally empty compilation unit
`timescale 1ns/1ps

// >>> pwr_ctrl_regs_bench.sv
// self-checking testbench for the power control register block
`timescale 1ns/1ps
`include "pwr_ctrl_consts.svh"

module pwr_ctrl_regs_bench;
    logic                    pclk;
    logic                    presetn;
    logic                    psel;
    logic                    penable;
    logic                    pwrite;
    logic [`PADDR_W-1:0]     paddr;
    logic [31:0]             pwdata;
    logic [31:0]             prdata;
    logic                    pready;
    logic                    pslverr;
    logic                    fast_internal_oscillator;
    logic                    low_speed_oscillator;
    logic                    booster_clk;
    pwr_ctrl_pkg::reg_ctrl_t reg_ctrl;
    logic [1:0]              fast_ph;
    logic [2:0]              slow_ph;
    int                      num_errors;
    int                      checks;

    pwr_ctrl_regs pwr_ctrl_regs_i (
        .pclk                     (pclk),
        .presetn                  (presetn),
        .psel                     (psel),
        .penable                  (penable),
        .pwrite                   (pwrite),
        .paddr                    (paddr),
        .pwdata                   (pwdata),
        .prdata                   (prdata),
        .pready                   (pready),
        .pslverr                  (pslverr),
        .fast_internal_oscillator (fast_internal_oscillator),
        .low_speed_oscillator     (low_speed_oscillator),
        .booster_clk              (booster_clk),
        .reg_ctrl                 (reg_ctrl)
    );

    always #5 pclk = ~pclk;

    // ---------------------------------------------------------------
    // oscillators: fast period 4 pclk, slow period 6 pclk
    // ---------------------------------------------------------------
    always @(posedge pclk) begin
        if (!presetn) begin
            fast_ph                  <= 2'h0;
            slow_ph                  <= 3'h0;
            fast_internal_oscillator <= 1'b0;
            low_speed_oscillator     <= 1'b0;
        end else begin
            fast_ph <= fast_ph + 2'h1;
            slow_ph <= (slow_ph == 3'h5) ? 3'h0 : slow_ph + 3'h1;
            fast_internal_oscillator <= fast_ph[1];
            low_speed_oscillator     <= (slow_ph < 3'h3);
        end
    end

    // ---------------------------------------------------------------
    // reporting
    // ---------------------------------------------------------------
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : wrap_up

    task automatic check(input string name, input logic [31:0] exp,
                         input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic timeout(input string name);
        num_errors++;
        $display("[FAIL] %s expected completion seen timeout", name);
        wrap_up();
    endtask : timeout

    // ---------------------------------------------------------------
    // apb transfers: request held until pready is seen at a rising edge
    // ---------------------------------------------------------------
    task automatic apb_xfer(input logic wr, input logic [`PADDR_W-1:0] addr,
                            input logic [31:0] wdata,
                            output logic [31:0] rdata, output logic err);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wdata;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) timeout("pready");
        rdata = prdata;
        err   = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb_xfer

    task automatic wr(input logic [`PADDR_W-1:0] addr, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb_xfer(1'b1, addr, d, r, e);
        check("write error", 32'h0, {31'h0, e});
    endtask : wr

    task automatic rd(input logic [`PADDR_W-1:0] addr, input logic [31:0] exp,
                      input logic exp_err);
        logic [31:0] r;
        logic        e;
        apb_xfer(1'b0, addr, 32'h0, r, e);
        check("read data", exp, r);
        check("read error", {31'h0, exp_err}, {31'h0, e});
    endtask : rd

    task automatic outs(input logic [2:0] exp);
        @(negedge pclk);
        check("reg_ctrl", {29'h0, exp}, {29'h0, reg_ctrl});
    endtask : outs

    // falling edge to falling edge of booster_clk, in pclk cycles
    task automatic measure(input string name, input int exp_per);
        int   n;
        int   t0;
        logic prev;
        n    = 0;
        t0   = -1;
        prev = booster_clk;
        while (n < 3 * exp_per + 200) begin
            @(negedge pclk);
            n++;
            if (booster_clk === 1'b0 && prev === 1'b1) begin
                if (t0 >= 0) begin
                    check(name, 32'(exp_per), 32'(n - t0));
                    return;
                end
                t0 = n;
            end
            prev = booster_clk;
        end
        timeout(name);
    endtask : measure

    task automatic quiet(input string name, input int cycles);
        logic seen;
        seen = 1'b0;
        // the output follows a register write one cycle late
        @(posedge pclk);
        repeat (cycles) begin
            @(negedge pclk);
            if (booster_clk !== 1'b0) seen = 1'b1;
        end
        check(name, 32'h0, {31'h0, seen});
    endtask : quiet

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        logic [31:0] r;
        logic        e;
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = 32'h0;
        num_errors = 0;
        checks = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        outs(3'b000);
        rd(`ADDR_BOOSTER_CLK, 32'h0, 1'b0);
        rd(`ADDR_LCD_REG, 32'h0, 1'b0);
        rd(`ADDR_CORE_REG, 32'h0, 1'b0);
        quiet("clock after reset", 300);
        $display("test reset_values done");

        wr(`ADDR_LCD_REG, 32'h10);
        outs(3'b100);
        rd(`ADDR_LCD_REG, 32'h10, 1'b0);
        wr(`ADDR_LCD_REG, 32'h01);
        outs(3'b010);
        rd(`ADDR_LCD_REG, 32'h01, 1'b0);
        wr(`ADDR_CORE_REG, 32'h20);
        outs(3'b011);
        rd(`ADDR_CORE_REG, 32'h20, 1'b0);
        apb_xfer(1'b1, 20'h14484, 32'h0, r, e);
        check("unmapped write error", 32'h1, {31'h0, e});
        rd(20'h14484, 32'h0, 1'b1);
        wr(`ADDR_CORE_REG, 32'h0);
        wr(`ADDR_LCD_REG, 32'h0);
        outs(3'b000);
        $display("test regulator_fields done");

        for (int dv = 0; dv < 7; dv++) begin
            wr(`ADDR_BOOSTER_CLK, 32'((dv << 4) | 1));
            rd(`ADDR_BOOSTER_CLK, 32'((dv << 4) | 1), 1'b0);
            measure("fast period", (64 << dv) * 4);
        end
        for (int dv = 0; dv < 4; dv++) begin
            wr(`ADDR_BOOSTER_CLK, 32'((dv << 4) | 5));
            rd(`ADDR_BOOSTER_CLK, 32'((dv << 4) | 5), 1'b0);
            measure("slow period", (8 << dv) * 6);
        end
        $display("test divider_ratios done");

        wr(`ADDR_BOOSTER_CLK, 32'h71);
        quiet("fast code 7", 800);
        wr(`ADDR_BOOSTER_CLK, 32'h45);
        quiet("slow code 4", 800);
        wr(`ADDR_BOOSTER_CLK, 32'h09);
        quiet("source code 2", 800);
        wr(`ADDR_BOOSTER_CLK, 32'h0d);
        rd(`ADDR_BOOSTER_CLK, 32'h0d, 1'b0);
        quiet("source code 3", 800);
        wr(`ADDR_BOOSTER_CLK, 32'h04);
        quiet("gate cleared", 200);
        $display("test reserved_and_gate done");
        wrap_up();
    end
endmodule : pwr_ctrl_regs_bench
